// ### hdl/dxa_ctrl.sv
module dxa_ctrl
   import dxa_pkg::*;
#(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input  wire logic           clk_in,
   input  wire logic           rst_n_in,
   // Host port
   input  dxa_pkg::dxa_host_t  host_in,
   output logic [7:0]          rd_data_out,
   // Strapped identity
   input  wire logic [3:0]     chip_identity_pins_in,
   // Channel access
   output dxa_pkg::dxa_chan_req_t chan_req_out,
   output dxa_pkg::dxa_sync_copy_t sync_copy_out,
   // Channel controls
   output logic [3:0]          start_pulse_out,
   output logic [3:0]          hop_pulse_out,
   output logic [3:0]          sleep_out,
   output logic [3:0]          pin_sync_enable_out,
   output logic                start_route_out,
   output logic                hop_route_out,
   output logic                first_sync_only_out,
   output logic                test_input_select_out,
   output logic                noise_source_select_out
);
   import dxa_pkg::*;

   initial
   begin
      if (CHANNELS != 4)
      begin
         $error("dxa_ctrl: channel decode serves exactly four channels");
      end
   end

   // ****************************************************
   // Register state
   // ****************************************************
   logic [7:0] access_control;
   logic [7:0] channel_address_pointer;
   logic [7:0] soft_sync_and_test_source;
   logic [7:0] pin_sync_routing;
   logic [7:0] sleep_and_page_select;

   // ****************************************************
   // Decode
   // ****************************************************
   wire logic       wr_acc   = host_in.wr && host_in.addr == DXA_OFF_ACCESS;
   wire logic       wr_ptr   = host_in.wr && host_in.addr == DXA_OFF_CHAN_PTR;
   wire logic       wr_soft  = host_in.wr && host_in.addr == DXA_OFF_SOFT_SYNC;
   wire logic       wr_pin   = host_in.wr && host_in.addr == DXA_OFF_PIN_SYNC;
   wire logic       wr_sleep = host_in.wr && host_in.addr == DXA_OFF_SLEEP;
   wire logic       wr_low   = host_in.wr && host_in.addr == DXA_OFF_DATA_LOW;
   wire logic       rd_low   = host_in.rd && host_in.addr == DXA_OFF_DATA_LOW;

   wire logic       autoinc  = access_control[DXA_ACC_AUTOINC_BIT];
   wire logic       bcast    = access_control[DXA_ACC_BCAST_BIT];
   wire logic [3:0] instr    = access_control[DXA_ACC_INSTR_LSB +: 4];
   wire logic [1:0] chan_sel = access_control[1:0];

   function automatic logic [3:0] one_chan(input logic [1:0] sel);
      one_chan = 4'h1 << sel;
   endfunction : one_chan

   // Broadcast decode; unlisted codes other than 0xc-0xf select nothing
   logic [3:0] bcast_mask;
   always_comb
   begin
      case (instr)
         DXA_INS_ALL:      bcast_mask = 4'hf;
         DXA_INS_CH012:    bcast_mask = 4'h7;
         DXA_INS_CH123:    bcast_mask = 4'he;
         DXA_INS_SEL_CH:   bcast_mask = one_chan(chan_sel);
         DXA_INS_ID0_LOW,
         DXA_INS_ID0_HIGH: bcast_mask = (chip_identity_pins_in[0] == instr[0])
                                        ? one_chan(chan_sel) : 4'h0;
         default:
         begin
            if (instr[3:2] == DXA_INS_ID10_TOP)
            begin
               bcast_mask = (chip_identity_pins_in[1:0] == instr[1:0])
                            ? one_chan(chan_sel) : 4'h0;
            end
            else
            begin
               bcast_mask = 4'h0;
            end
         end
      endcase
   end

   wire logic [3:0] direct_mask = (instr == chip_identity_pins_in)
                                  ? one_chan(chan_sel) : 4'h0;
   wire logic [3:0] chan_mask   = bcast ? bcast_mask : direct_mask;
   wire logic       launch      = (wr_low || rd_low) && chan_mask != 4'h0;
   // Reads during broadcast would collide on the internal bus
   wire logic       rd_launch   = rd_low && !bcast && direct_mask != 4'h0;

   wire logic [7:0] next_ptr = wr_ptr ? host_in.data
                             : (launch && autoinc) ? 8'(channel_address_pointer + 8'h01)
                             : channel_address_pointer;

   // Reserved bits kept at zero regardless of what the host writes
   wire logic [7:0] pin_wdata   = {1'b0, host_in.data[6:0]};
   wire logic [7:0] sleep_wdata = {2'b00, host_in.data[5], 1'b0, host_in.data[3:0]};

   // Readback only of the pointer and access control; the pointer reads zero under broadcast
   wire logic [7:0] next_rd = (host_in.addr == DXA_OFF_ACCESS)   ? access_control
                            : (host_in.addr == DXA_OFF_CHAN_PTR && !bcast) ? channel_address_pointer
                            : 8'h00;

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         access_control <= DXA_RST_BYTE;
      end
      else if (wr_acc)
      begin
         access_control <= host_in.data;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         channel_address_pointer <= DXA_RST_BYTE;
      end
      else
      begin
         channel_address_pointer <= next_ptr;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         soft_sync_and_test_source <= DXA_RST_BYTE;
      end
      else if (wr_soft)
      begin
         // Pulse bits are not held; they live only in the one-shot
         soft_sync_and_test_source <= host_in.data & 8'hcf;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pin_sync_routing <= DXA_RST_BYTE;
      end
      else if (wr_pin)
      begin
         pin_sync_routing <= pin_wdata;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sleep_and_page_select <= DXA_RST_BYTE;
      end
      else if (wr_sleep)
      begin
         sleep_and_page_select <= sleep_wdata;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   dxa_oneshot #(.WIDTH(4)) u_start_shot (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .fire_in   (wr_soft && host_in.data[DXA_SS_START_BIT]),
      .mask_in   (host_in.data[3:0]),
      .pulse_out (start_pulse_out)
   );

   dxa_oneshot #(.WIDTH(4)) u_hop_shot (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .fire_in   (wr_soft && host_in.data[DXA_SS_HOP_BIT]),
      .mask_in   (host_in.data[3:0]),
      .pulse_out (hop_pulse_out)
   );

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_out <= DXA_RST_BYTE;
      end
      else
      begin
         rd_data_out <= next_rd;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         chan_req_out <= '0;
      end
      else
      begin
         chan_req_out.wr        <= wr_low && launch;
         chan_req_out.rd        <= rd_launch;
         chan_req_out.chan_mask <= chan_mask;
         chan_req_out.out_page  <= sleep_and_page_select[DXA_SL_PAGE_BIT];
         chan_req_out.addr      <= channel_address_pointer;
      end
   end

   // A pin-sync write carries fresh fields; a soft-sync write repeats the stored ones
   wire logic [3:0] copy_mask = wr_soft ? host_in.data[3:0] : 4'hf;
   wire logic [7:0] copy_src  = wr_pin ? pin_wdata : pin_sync_routing;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync_copy_out <= '0;
      end
      else
      begin
         // Copy into each masked channel's 0x82 on soft sync writes, into all four on pin sync writes
         sync_copy_out.valid      <= wr_soft || wr_pin;
         sync_copy_out.chan_mask  <= copy_mask;
         sync_copy_out.first_only <= copy_src[DXA_PS_FIRST_BIT];
         sync_copy_out.hop_en     <= copy_src[DXA_PS_HOP_EN_BIT];
         sync_copy_out.start_en   <= copy_src[DXA_PS_START_EN_BIT];
      end
   end

   // Straight flops of the stored sleep and pin-sync fields
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sleep_out           <= 4'h0;
         pin_sync_enable_out <= 4'h0;
         start_route_out     <= 1'b0;
         hop_route_out       <= 1'b0;
         first_sync_only_out <= 1'b0;
      end
      else
      begin
         sleep_out           <= sleep_and_page_select[3:0];
         pin_sync_enable_out <= pin_sync_routing[3:0];
         start_route_out     <= pin_sync_routing[DXA_PS_START_EN_BIT];
         hop_route_out       <= pin_sync_routing[DXA_PS_HOP_EN_BIT];
         first_sync_only_out <= pin_sync_routing[DXA_PS_FIRST_BIT];
      end
   end

   // Test source controls stay levels; only the pulse bits are dropped
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         test_input_select_out   <= 1'b0;
         noise_source_select_out <= 1'b0;
      end
      else
      begin
         test_input_select_out   <= soft_sync_and_test_source[DXA_SS_TEST_SEL_BIT];
         noise_source_select_out <= soft_sync_and_test_source[DXA_SS_NOISE_BIT];
      end
   end

endmodule : dxa_ctrl

// ### hdl/dxa_pkg.sv
package dxa_pkg;

   // ****************************************************
   // External page offsets
   // ****************************************************
   localparam logic [2:0] DXA_OFF_DATA_LOW   = 3'h0;
   localparam logic [2:0] DXA_OFF_DATA_MID   = 3'h1;
   localparam logic [2:0] DXA_OFF_DATA_HIGH  = 3'h2;
   localparam logic [2:0] DXA_OFF_SLEEP      = 3'h3;
   localparam logic [2:0] DXA_OFF_PIN_SYNC   = 3'h4;
   localparam logic [2:0] DXA_OFF_SOFT_SYNC  = 3'h5;
   localparam logic [2:0] DXA_OFF_CHAN_PTR   = 3'h6;
   localparam logic [2:0] DXA_OFF_ACCESS     = 3'h7;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int DXA_ACC_AUTOINC_BIT  = 7;
   localparam int DXA_ACC_BCAST_BIT    = 6;
   localparam int DXA_ACC_INSTR_LSB    = 2;
   localparam int DXA_SS_START_BIT     = 4;
   localparam int DXA_SS_HOP_BIT       = 5;
   localparam int DXA_SS_TEST_SEL_BIT  = 6;
   localparam int DXA_SS_NOISE_BIT     = 7;
   localparam int DXA_PS_START_EN_BIT  = 4;
   localparam int DXA_PS_HOP_EN_BIT    = 5;
   localparam int DXA_PS_FIRST_BIT     = 6;
   localparam int DXA_SL_PAGE_BIT      = 5;

   // ****************************************************
   // Reset values and decode constants
   // ****************************************************
   localparam logic [7:0] DXA_RST_BYTE      = 8'h00;
   localparam logic [7:0] DXA_CH_PIN_SYNC   = 8'h82;
   localparam logic [3:0] DXA_INS_ALL       = 4'h0;
   localparam logic [3:0] DXA_INS_CH012     = 4'h1;
   localparam logic [3:0] DXA_INS_CH123     = 4'h2;
   localparam logic [3:0] DXA_INS_SEL_CH    = 4'h4;
   localparam logic [3:0] DXA_INS_ID0_LOW   = 4'h8;
   localparam logic [3:0] DXA_INS_ID0_HIGH  = 4'h9;
   localparam logic [1:0] DXA_INS_ID10_TOP  = 2'h3;

   // Host strobe towards the external page
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] data;
   } dxa_host_t;

   // Internal channel access launched by the data low register
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] chan_mask;
      logic       out_page;
      logic [7:0] addr;
   } dxa_chan_req_t;

   // Per-channel sync copy written to channel address 0x82
   typedef struct packed {
      logic       valid;
      logic [3:0] chan_mask;
      logic       first_only;
      logic       hop_en;
      logic       start_en;
   } dxa_sync_copy_t;

endpackage : dxa_pkg

// ### hdl/dxa_oneshot.sv
// Turns a written bit into a single-cycle pulse per channel
module dxa_oneshot #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // Trigger
   input  wire logic             fire_in,
   input  wire logic [WIDTH-1:0] mask_in,
   // Pulse
   output logic      [WIDTH-1:0] pulse_out
);

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("dxa_oneshot: WIDTH must be at least 1");
      end
   end

   // Pulse is registered for one cycle and clears on the next unless fired again
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pulse_out <= '0;
      end
      else
      begin
         pulse_out <= fire_in ? mask_in : '0;
      end
   end

endmodule : dxa_oneshot

// ### testbench/dxa_ctrl_sva.sv
module dxa_ctrl_sva
   import dxa_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // Watched ports
   input  dxa_pkg::dxa_host_t     host_in,
   input  wire logic [3:0]        chip_identity_pins_in,
   input  dxa_pkg::dxa_chan_req_t chan_req_out,
   input  dxa_pkg::dxa_sync_copy_t sync_copy_out,
   input  wire logic [3:0]        start_pulse_out,
   input  wire logic [3:0]        hop_pulse_out,
   input  wire logic [3:0]        sleep_out,
   input  wire logic [3:0]        pin_sync_enable_out,
   input  wire logic              start_route_out,
   input  wire logic              test_input_select_out,
   input  wire logic              noise_source_select_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ****
   // Shadow of the access control byte, needed to judge launches
   // ****
   logic [7:0] acc;
   wire w0 = host_in.wr && host_in.addr == DXA_OFF_DATA_LOW;
   wire r0 = host_in.rd && host_in.addr == DXA_OFF_DATA_LOW;
   wire w3 = host_in.wr && host_in.addr == DXA_OFF_SLEEP;
   wire w4 = host_in.wr && host_in.addr == DXA_OFF_PIN_SYNC;
   wire w5 = host_in.wr && host_in.addr == DXA_OFF_SOFT_SYNC;
   wire hit = !acc[6] && acc[5:2] == chip_identity_pins_in;
   always_ff @(posedge clk_in or negedge rst_n_in)
      if (!rst_n_in)
         acc <= 8'h00;
      else if (host_in.wr && host_in.addr == DXA_OFF_ACCESS)
         acc <= host_in.data;
   sequence soft_start;
      w5 && host_in.data[DXA_SS_START_BIT];
   endsequence
   sequence soft_hop;
      w5 && host_in.data[DXA_SS_HOP_BIT];
   endsequence
   start_pulse_a: assert property (soft_start |=> start_pulse_out == $past(host_in.data[3:0]))
      else $error("start pulse mask wrong");
   hop_pulse_a: assert property (soft_hop |=> hop_pulse_out == $past(host_in.data[3:0]))
      else $error("hop pulse mask wrong");
   mask_only_a: assert property (w5 && host_in.data[5:4] == 2'h0 |=> (start_pulse_out | hop_pulse_out) == 4'h0)
      else $error("pulse without trigger bit");
   pulse_once_a: assert property (start_pulse_out != 4'h0 && !(w5 && host_in.data[DXA_SS_START_BIT])
      |=> start_pulse_out == 4'h0)
      else $error("start pulse longer than one cycle");
   sleep_level_a: assert property (w3 |-> ##2 sleep_out == $past(host_in.data[3:0], 2))
      else $error("sleep level wrong");
   pin_level_a: assert property (w4 |-> ##2 pin_sync_enable_out == $past(host_in.data[3:0], 2)
      && start_route_out == $past(host_in.data[4], 2))
      else $error("pin sync level wrong");
   test_level_a: assert property (w5 |-> ##2 test_input_select_out == $past(host_in.data[6], 2)
      && noise_source_select_out == $past(host_in.data[7], 2))
      else $error("test source level wrong");
   sync_copy_a: assert property (w4 || w5 |=> sync_copy_out.valid)
      else $error("sync copy missing");
   id_launch_a: assert property (w0 && hit |=> chan_req_out.wr
      && chan_req_out.chan_mask == 4'h1 << $past(acc[1:0]))
      else $error("matched write not launched");
   id_miss_a: assert property (w0 && !acc[6] && !hit |=> !chan_req_out.wr)
      else $error("unmatched write launched");
   bcast_read_a: assert property (r0 && acc[6] |=> !chan_req_out.rd)
      else $error("read launched under broadcast");
endmodule : dxa_ctrl_sva

bind dxa_ctrl dxa_ctrl_sva u_sva (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_in(host_in),
   .chip_identity_pins_in(chip_identity_pins_in), .chan_req_out(chan_req_out),
   .sync_copy_out(sync_copy_out), .start_pulse_out(start_pulse_out), .hop_pulse_out(hop_pulse_out),
   .sleep_out(sleep_out), .pin_sync_enable_out(pin_sync_enable_out), .start_route_out(start_route_out),
   .test_input_select_out(test_input_select_out), .noise_source_select_out(noise_source_select_out));

// ### testbench/dxa_host_model.sv
module dxa_host_model
   import dxa_pkg::*;
(
   // Clock
   input  wire logic        clk_in,
   // Host side of the page
   input  wire logic [7:0]  rd_data_in,
   output dxa_pkg::dxa_host_t host_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // One strobe cycle; released fields show the inverse so stale values never pass
   // ****
   initial host_out = '0;
   task automatic access(input logic wr, input logic rd, input logic [2:0] addr, input logic [7:0] data,
                         output logic [7:0] rdata);
      @(negedge clk_in);
      host_out = '{wr: wr, rd: rd, addr: addr, data: data};
      @(negedge clk_in);
      rdata = rd_data_in;
      host_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
   endtask : access
endmodule : dxa_host_model

// ### testbench/ddc_external_access_control_tb.sv
module ddc_external_access_control_tb;
   import dxa_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   dxa_host_t host;
   dxa_chan_req_t req;
   dxa_sync_copy_t cp;
   logic [7:0] rdat, v;
   logic [3:0] sp, hp, sl, pse;
   logic sr, hr, fo, ts, ns;
   logic [3:0] chip_id = 4'h5;
   logic [3:0] em;
   int err_count = 0;
   int checks = 0;
   logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
   logic [3:0] masks [11] = '{4'hf, 4'h7, 4'he, 4'h0, 4'h4, 4'h0, 4'h4, 4'h0, 4'h4, 4'h0, 4'h0};
   logic [3:0] masks_b [11] = '{4'hf, 4'h7, 4'he, 4'h0, 4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'h4, 4'h0};
   always #20 clk_in = ~clk_in;
   dxa_host_model u_host (.clk_in(clk_in), .rd_data_in(rdat), .host_out(host));
   dxa_ctrl u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_in(host), .rd_data_out(rdat),
      .chip_identity_pins_in(chip_id), .chan_req_out(req), .sync_copy_out(cp), .start_pulse_out(sp),
      .hop_pulse_out(hp), .sleep_out(sl), .pin_sync_enable_out(pse), .start_route_out(sr),
      .hop_route_out(hr), .first_sync_only_out(fo), .test_input_select_out(ts),
      .noise_source_select_out(ns));
   // ****
   // Access and compare tasks
   // ****
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] x;
      u_host.access(1'b1, 1'b0, a, d, x);
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      u_host.access(1'b0, 1'b1, a, 8'h00, d);
   endtask : rd
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      #100us;
      err_count++;
      give_verdict();
   end
   // ****
   // Tests
   // ****
   initial
   begin
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
      chk("reset", 8'h00, {sl, pse});
      wr(3'h6, 8'h10);
      wr(3'h7, 8'h96);
      rd(3'h7, v);
      chk("acc", 8'h96, v);
      wr(3'h0, 8'h3c);
      chk("launch", 8'h14, {3'h0, req.wr, req.chan_mask});
      chk("addr0", 8'h10, req.addr);
      wr(3'h0, 8'h3d);
      chk("addr1", 8'h11, req.addr);
      rd(3'h0, v);
      chk("rlaunch", 8'h01, {7'h0, req.rd});
      rd(3'h6, v);
      chk("ptr", 8'h13, v);
      wr(3'h7, 8'h18);
      wr(3'h0, 8'h01);
      chk("miss", 8'h00, {7'h0, req.wr});
      $display("test pointer done");
      for (int k = 0; k < 2; k++)
      begin
         chip_id = (k == 0) ? 4'h5 : 4'ha;
         for (int i = 0; i < 11; i++)
         begin
            wr(3'h7, {2'b01, codes[i], 2'b10});
            wr(3'h0, 8'h5a);
            em = (k == 0) ? masks[i] : masks_b[i];
            chk("bcast", {3'h0, em != 4'h0, em}, {3'h0, req.wr, req.wr ? req.chan_mask : 4'h0});
         end
      end
      chip_id = 4'h5;
      rd(3'h6, v);
      chk("bc_ptr", 8'h00, v);
      rd(3'h0, v);
      chk("bc_rd", 8'h00, {7'h0, req.rd});
      wr(3'h7, 8'h16);
      $display("test broadcast done");
      wr(3'h5, 8'h9a);
      chk("start", 8'ha0, {sp, hp});
      chk("sc_copy", 8'h1a, {3'h0, cp.valid, cp.chan_mask});
      @(negedge clk_in);
      chk("once", 8'h01, {2'h0, sp, ts, ns});
      wr(3'h5, 8'h65);
      chk("hop", 8'h05, {sp, hp});
      @(negedge clk_in);
      chk("test", 8'h02, {6'h0, ts, ns});
      wr(3'h5, 8'h0f);
      chk("none", 8'h00, {sp, hp});
      $display("test soft sync done");
      wr(3'h4, 8'h7f);
      chk("copy", 8'h0f, {4'h0, cp.valid, cp.first_only, cp.hop_en, cp.start_en});
      chk("copy_mask", 8'h0f, {4'h0, cp.chan_mask});
      @(negedge clk_in);
      chk("pins", 8'h7f, {1'b0, fo, hr, sr, pse});
      wr(3'h4, 8'h52);
      @(negedge clk_in);
      chk("pins2", 8'h52, {1'b0, fo, hr, sr, pse});
      wr(3'h3, 8'h25);
      @(negedge clk_in);
      chk("sleep", 8'h05, {4'h0, sl});
      wr(3'h0, 8'h00);
      chk("page", 8'h01, {7'h0, req.out_page});
      wr(3'h3, 8'h00);
      wr(3'h0, 8'h00);
      chk("page0", 8'h00, {7'h0, req.out_page});
      $display("test pin sync and sleep done");
      give_verdict();
   end
endmodule : ddc_external_access_control_tb
